// [lapc_pkg.sv]
// Package of constants and types for the loop access panel control block.
`default_nettype none
package lapc_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses on APB)
  // ----------------------------------------------------------------------
  localparam logic [11:0] LAPC_ADDR_CTRL = 12'h000;
  localparam logic [11:0] LAPC_ADDR_KEYS = 12'h004;
  localparam logic [11:0] LAPC_ADDR_SEL = 12'h008;
  localparam logic [11:0] LAPC_ADDR_STAT = 12'h00c;
  localparam logic [11:0] LAPC_ADDR_ADDR = 12'h010;
  localparam logic [11:0] LAPC_ADDR_LAMP = 12'h014;

  // CTRL register fields and reset value.
  localparam int LAPC_CTRL_REMOTE_BIT = 0;
  localparam int LAPC_CTRL_UNIT_BIT = 1;
  localparam logic [1:0] LAPC_CTRL_RESET = 2'h0;

  // KEYS register: write-one pulse bits.
  localparam int LAPC_KEY_DIGIT_BIT = 4;
  localparam int LAPC_KEY_MON_BIT = 8;
  localparam int LAPC_KEY_BRK_BIT = 9;
  localparam int LAPC_KEY_RELEASE_KEY_BIT = 10;
  localparam int LAPC_KEY_RELEASE_CIRCUIT_KEY_BIT = 11;
  localparam int LAPC_KEY_EXT_BIT = 12;
  localparam int LAPC_KEY_METER_ON_KEY_BIT = 13;
  localparam int LAPC_KEY_METER_REVERSE_KEY_BIT = 14;
  localparam int LAPC_KEY_ZERO_BIT = 15;

  // SEL register fields and reset values.
  localparam int LAPC_SEL_FUNC_LSB = 0;
  localparam int LAPC_SEL_PAIR_LSB = 4;
  localparam logic [3:0] LAPC_FUNC_RESET = 4'h1;
  localparam logic [9:0] LAPC_PAIR_RESET = 10'h001;

  // Address digits: four BCD nibbles, blank code shows nothing.
  localparam logic [3:0] LAPC_DIGIT_BLANK = 4'hf;
  localparam logic [1:0] LAPC_DIGITS_PER_FIELD = 2'h2;

  // Matrix relay sense settle time before the fault check is made.
  localparam int LAPC_SETTLE_NS = 1000;
  localparam int LAPC_CLK_NS = 10;
  localparam int LAPC_SETTLE_CYC = LAPC_SETTLE_NS / LAPC_CLK_NS;

  typedef enum logic [1:0] {
    LAPC_IDLE = 2'b00,
    LAPC_SETTLE = 2'b01,
    LAPC_HELD = 2'b10,
    LAPC_FAULTED = 2'b11
  } lapc_state_t;

endpackage : lapc_pkg
`default_nettype wire

// [lapc_top.sv]
// Loop access panel control: keypad address entry, matrix relay drive and test panel gating.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Remote control blanks displays, ignores panel
// - Monitor on channel unit: monitor relay only
// - Break on channel unit: both relays
// - Break on channel unit: line and equipment buses
// - First two digits bay, next two circuit
// - Readout updates after every keyed digit
// - Remote indicator lit: lamps dark, displays blank
// - Manual operation only while indicator dark
// - Good monitor access keeps monitor key lit
// - Monitor on loop unit lights fault
// - Break: loop unit line bus only
// - Fault on loop monitor, multiple, none
// - Fault held until circuit released
// - Release disconnects and darkens access key
// - Release circuit blanks circuit, keeps bay
// - External measure toggles, inhibits internal, jacks
// - Meter off whenever circuit released
// - Meter on only after full address
// - Meter reverse toggles, swaps meter inputs
// - Function select one-hot, key lit
// - Cable pair one-hot of ten, lit
// - Controller takeover ends manual test

module lapc_top
  import lapc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic remote_in,
  input wire logic [1:0] relay_sense,
  output logic remote_control_indicator,
  output logic monitor_relay,
  output logic break_relay,
  output logic line_bus_en,
  output logic equip_bus_en,
  output logic ext_route_en,
  output logic meter_on,
  output logic meter_swap,
  output logic jack_en,
  output logic [15:0] address_readout,
  output logic [15:0] lamps
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [2:0] remote_sync_reg;
  logic remote_reg;
  logic loop_unit_reg;
  logic [3:0] digit_reg [0:3];
  logic [2:0] digit_count_reg;
  lapc_state_t state_reg;
  logic brk_mode_reg;
  logic [7:0] settle_reg;
  logic fault_reg;
  logic ext_reg;
  logic meter_reg;
  logic rvs_reg;
  logic zero_reg;
  logic [3:0] func_reg;
  logic [9:0] pair_reg;
  logic [31:0] prdata_next;

  // APB write strobe, taken at the access edge only.
  logic wr_en;
  logic key_wr;
  logic manual_ok;
  logic accessed;
  logic full_addr;
  logic [3:0] key_digit;
  assign wr_en = psel & penable & pwrite;
  assign key_wr = wr_en & (paddr == LAPC_ADDR_KEYS);
  assign manual_ok = ~remote_reg;
  assign accessed = (state_reg == LAPC_HELD);
  assign full_addr = (digit_count_reg == 3'h4);
  assign key_digit = pwdata[3:0];

  // Key press decodes; every panel key is dropped under remote control.
  logic k_digit, k_mon, k_brk, k_release_key, k_rckt, k_ext, k_mtr, k_rvs, k_zero;
  assign k_digit = key_wr & manual_ok & pwdata[LAPC_KEY_DIGIT_BIT] & (key_digit < 4'ha);
  assign k_mon = key_wr & manual_ok & pwdata[LAPC_KEY_MON_BIT];
  assign k_brk = key_wr & manual_ok & pwdata[LAPC_KEY_BRK_BIT];
  assign k_release_key = key_wr & manual_ok & pwdata[LAPC_KEY_RELEASE_KEY_BIT];
  assign k_rckt = key_wr & manual_ok & pwdata[LAPC_KEY_RELEASE_CIRCUIT_KEY_BIT];
  assign k_ext = key_wr & manual_ok & pwdata[LAPC_KEY_EXT_BIT];
  assign k_mtr = key_wr & manual_ok & pwdata[LAPC_KEY_METER_ON_KEY_BIT];
  assign k_rvs = key_wr & manual_ok & pwdata[LAPC_KEY_METER_REVERSE_KEY_BIT];
  assign k_zero = key_wr & manual_ok & pwdata[LAPC_KEY_ZERO_BIT];

  // Any release of the circuit: keys, or controller takeover.
  logic release_any;
  assign release_any = k_release_key | k_rckt | (remote_reg & (state_reg != LAPC_IDLE));

  // ----------------------------------------------------------------------
  // Remote-control input synchroniser
  // ----------------------------------------------------------------------
  // The pin is asynchronous; a change counts once stages two and three agree.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      remote_sync_reg <= 3'h0;
      remote_reg <= 1'b0;
    end
    else
    begin
      remote_sync_reg <= {remote_sync_reg[1:0], remote_in};
      if (remote_sync_reg[1] == remote_sync_reg[2])
        remote_reg <= remote_sync_reg[2];
    end
  end

  // ----------------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------------
  // Unit type of the addressed matrix unit is supplied by software.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      loop_unit_reg <= LAPC_CTRL_RESET[LAPC_CTRL_UNIT_BIT];
    else if (wr_en && paddr == LAPC_ADDR_CTRL)
      loop_unit_reg <= pwdata[LAPC_CTRL_UNIT_BIT];
  end

  // ----------------------------------------------------------------------
  // Address digit entry
  // ----------------------------------------------------------------------
  // Digits fill bay then circuit; the count shows the readout at each step.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 4; i++)
        digit_reg[i] <= LAPC_DIGIT_BLANK;
      digit_count_reg <= 3'h0;
    end
    else if (k_rckt)
    begin
      // Circuit digits blank, bay digits stay for a new circuit.
      digit_reg[2] <= LAPC_DIGIT_BLANK;
      digit_reg[3] <= LAPC_DIGIT_BLANK;
      if (digit_count_reg > {1'b0, LAPC_DIGITS_PER_FIELD})
        digit_count_reg <= {1'b0, LAPC_DIGITS_PER_FIELD};
    end
    else if (k_digit && !full_addr && state_reg == LAPC_IDLE)
    begin
      digit_reg[digit_count_reg[1:0]] <= key_digit;
      digit_count_reg <= digit_count_reg + 3'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Access state machine and fault lamp
  // ----------------------------------------------------------------------
  // The relay sense is checked only after a settle time so a slow relay is not a fault.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= LAPC_IDLE;
      brk_mode_reg <= 1'b0;
      settle_reg <= 8'h0;
      fault_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        LAPC_IDLE:
        begin
          if (k_mon && full_addr && loop_unit_reg)
          begin
            fault_reg <= 1'b1;
            brk_mode_reg <= 1'b0;
            state_reg <= LAPC_FAULTED;
          end
          else if ((k_mon || k_brk) && full_addr)
          begin
            brk_mode_reg <= k_brk;
            settle_reg <= 8'(LAPC_SETTLE_CYC);
            state_reg <= LAPC_SETTLE;
          end
        end
        LAPC_SETTLE:
        begin
          if (release_any)
            state_reg <= LAPC_IDLE;
          else if (settle_reg != 8'h0)
            settle_reg <= settle_reg - 8'h1;
          else if (relay_sense == 2'b01)
            state_reg <= LAPC_HELD;
          else
          begin
            fault_reg <= 1'b1;
            state_reg <= LAPC_FAULTED;
          end
        end
        LAPC_HELD:
        begin
          if (release_any)
            state_reg <= LAPC_IDLE;
        end
        LAPC_FAULTED:
        begin
          if (release_any)
          begin
            fault_reg <= 1'b0;
            state_reg <= LAPC_IDLE;
          end
        end
        default:
          state_reg <= LAPC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Meter, external measure and zero check
  // ----------------------------------------------------------------------
  // The meter drops on every release so it never sits across a monitored line.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meter_reg <= 1'b0;
      ext_reg <= 1'b0;
    end
    else if (release_any)
    begin
      meter_reg <= 1'b0;
      ext_reg <= 1'b0;
    end
    else
    begin
      if (k_mtr && full_addr)
        meter_reg <= 1'b1;
      if (k_ext && accessed)
        ext_reg <= ~ext_reg;
    end
  end

  // Meter reverse and zero check are alternate action keys.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rvs_reg <= 1'b0;
      zero_reg <= 1'b0;
    end
    else
    begin
      if (k_rvs)
        rvs_reg <= ~rvs_reg;
      if (k_zero)
        zero_reg <= ~zero_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Function and cable pair selection
  // ----------------------------------------------------------------------
  // A field that is not written exactly one-hot keeps its value, as the interlock would refuse it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      func_reg <= LAPC_FUNC_RESET;
      pair_reg <= LAPC_PAIR_RESET;
    end
    else if (wr_en && manual_ok && paddr == LAPC_ADDR_SEL)
    begin
      if ($onehot(pwdata[LAPC_SEL_FUNC_LSB +: 4]))
        func_reg <= pwdata[LAPC_SEL_FUNC_LSB +: 4];
      if ($onehot(pwdata[LAPC_SEL_PAIR_LSB +: 10]))
        pair_reg <= pwdata[LAPC_SEL_PAIR_LSB +: 10];
    end
  end

  // ----------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------
  // Relays follow the access state; a loop unit break drives only the line bus.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      monitor_relay <= 1'b0;
      break_relay <= 1'b0;
      line_bus_en <= 1'b0;
      equip_bus_en <= 1'b0;
    end
    else
    begin
      monitor_relay <= (state_reg == LAPC_SETTLE || accessed) & ~release_any;
      break_relay <= (state_reg == LAPC_SETTLE || accessed) & ~release_any & brk_mode_reg;
      line_bus_en <= accessed & ~release_any & ~ext_reg;
      equip_bus_en <= accessed & ~release_any & brk_mode_reg & ~loop_unit_reg & ~ext_reg;
    end
  end

  // Panel lamps and readout all go dark under remote control.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      remote_control_indicator <= 1'b0;
      ext_route_en <= 1'b0;
      meter_on <= 1'b0;
      meter_swap <= 1'b0;
      jack_en <= 1'b0;
      address_readout <= {4{LAPC_DIGIT_BLANK}};
      lamps <= 16'h0;
    end
    else
    begin
      remote_control_indicator <= remote_reg;
      ext_route_en <= ext_reg & accessed;
      meter_on <= meter_reg & ~ext_reg & ~remote_reg;
      meter_swap <= rvs_reg & meter_reg;
      jack_en <= accessed & ~ext_reg & ~remote_reg;
      if (remote_reg)
      begin
        address_readout <= {4{LAPC_DIGIT_BLANK}};
        lamps <= 16'h0;
      end
      else
      begin
        address_readout <= {digit_reg[0], digit_reg[1], digit_reg[2], digit_reg[3]};
        lamps <= {func_reg, zero_reg, rvs_reg, meter_reg, ext_reg, fault_reg,
                  accessed & brk_mode_reg, accessed & ~brk_mode_reg, 5'h0};
      end
    end
  end

  // ----------------------------------------------------------------------
  // APB slave: zero wait states, unmapped reads zero with an error
  // ----------------------------------------------------------------------
  always_comb
  begin
    prdata_next = 32'h0;
    case (paddr)
      LAPC_ADDR_CTRL: prdata_next = {30'h0, loop_unit_reg, remote_reg};
      LAPC_ADDR_KEYS: prdata_next = 32'h0;
      LAPC_ADDR_SEL: prdata_next = {18'h0, pair_reg, func_reg};
      LAPC_ADDR_STAT: prdata_next = {22'h0, relay_sense, zero_reg, rvs_reg, meter_reg, ext_reg,
                                     fault_reg, brk_mode_reg, state_reg};
      LAPC_ADDR_ADDR: prdata_next = {13'h0, digit_count_reg,
                                     digit_reg[0], digit_reg[1], digit_reg[2], digit_reg[3]};
      LAPC_ADDR_LAMP: prdata_next = {6'h0, pair_reg, lamps};
      default: prdata_next = 32'h0;
    endcase
  end

  // Read data and the answer are registered in the setup cycle so they stand in the access cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable;
      prdata <= (psel & ~penable & ~pwrite) ? prdata_next : 32'h0;
      pslverr <= psel & ~penable & ~(paddr inside {LAPC_ADDR_CTRL, LAPC_ADDR_KEYS, LAPC_ADDR_SEL,
                                                  LAPC_ADDR_STAT, LAPC_ADDR_ADDR, LAPC_ADDR_LAMP});
    end
  end

endmodule // lapc_top
`default_nettype wire

// [lapc_far_model.sv]
// Model of the relay matrix sense lines and the supervising controller.
`timescale 1ns/1ns
`default_nettype none
module lapc_far_model
(
  input wire logic pclk,
  input wire logic monitor_relay,
  input wire logic [1:0] sense_mode,
  input wire logic take_over,
  output logic [1:0] relay_sense,
  output logic remote_in
);
  // ----------------------------------------------------------------------
  // Matrix sense and controller command
  // ----------------------------------------------------------------------
  // An undriven matrix reports no relay energised, so a count only shows once driven.
  assign relay_sense = monitor_relay ? sense_mode : 2'h0;
  // The controller moves its command line just after an edge, as real logic would.
  always_ff @(posedge pclk) remote_in <= take_over;
endmodule // lapc_far_model
`default_nettype wire

// [lapc_top_assertions.sv]
// Concurrent checks on the ports of the loop access panel control block.
`timescale 1ns/1ns
`default_nettype none
module lapc_top_assertions
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic remote_control_indicator,
  input wire logic monitor_relay,
  input wire logic break_relay,
  input wire logic line_bus_en,
  input wire logic equip_bus_en,
  input wire logic ext_route_en,
  input wire logic meter_on,
  input wire logic jack_en,
  input wire logic [15:0] address_readout,
  input wire logic [15:0] lamps
);
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  // One clock domain, so clocking and reset are stated once.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held too long");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_remote_blanks: assert property (remote_control_indicator |->
    lamps == 16'h0 && address_readout == 16'hffff) else $error("panel lit under remote");
  a_takeover_drops: assert property ($rose(remote_control_indicator) |-> ##[0:3] !monitor_relay)
    else $error("access kept after takeover");
  a_break_pair: assert property (break_relay |-> monitor_relay) else $error("break relay alone");
  a_equip_break: assert property (equip_bus_en |-> break_relay) else $error("equipment bus without break");
  a_ext_inhibit: assert property (ext_route_en |-> !jack_en && !line_bus_en) else $error("ext with internal");
  a_access_ends: assert property ($rose(monitor_relay) |-> ##[1:110] (line_bus_en || lamps[7]))
    else $error("access never settled");
  a_release_meter: assert property ($fell(monitor_relay) |-> ##[0:2] !meter_on) else $error("meter kept");
  a_func_onehot: assert property ($onehot(lamps[15:12]) || lamps[15:12] == 4'h0) else $error("function lamps");
  c_line_up: cover property ($rose(line_bus_en));
  c_fault: cover property ($rose(lamps[7]));
  c_remote: cover property ($rose(remote_control_indicator));
endmodule // lapc_top_assertions
bind lapc_top lapc_top_assertions lapc_top_assertions_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .remote_control_indicator(remote_control_indicator),
  .monitor_relay(monitor_relay), .break_relay(break_relay), .line_bus_en(line_bus_en),
  .equip_bus_en(equip_bus_en), .ext_route_en(ext_route_en), .meter_on(meter_on), .jack_en(jack_en),
  .address_readout(address_readout), .lamps(lamps));
`default_nettype wire

// [lapc_top_tb.sv]
// Self-checking testbench for the loop access panel control block.
`timescale 1ns/1ns
`default_nettype none
module lapc_top_tb;
  import lapc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, remote_in, take_over, z;
  logic rci, mon, break_access_key, line, equip, ext, mtr, swp, jack;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0] relay_sense, sense_mode;
  logic [15:0] readout, lamps, exp_ro;
  logic [64:0] notes[$];
  logic [64:0] nt;
  logic [9:0] t;
  logic [4:0] m;
  int num_errors, samples_checked, i, k, nd;
  // Access cases: unit, break key, sense mode, spare, then {fault, line, equip, brk, mon}.
  logic [9:0] tbl [6] = '{10'b0_0_01_0_01001, 10'b0_1_01_0_01111, 10'b0_1_00_0_10000,
    10'b0_1_10_0_10000, 10'b1_0_01_0_10000, 10'b1_1_01_0_01010};
  lapc_top lapc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .remote_in(remote_in), .relay_sense(relay_sense), .remote_control_indicator(rci), .monitor_relay(mon),
    .break_relay(break_access_key), .line_bus_en(line), .equip_bus_en(equip), .ext_route_en(ext), .meter_on(mtr),
    .meter_swap(swp), .jack_en(jack), .address_readout(readout), .lamps(lamps));
  lapc_far_model lapc_far_model_i (.pclk(pclk), .monitor_relay(mon), .sense_mode(sense_mode),
    .take_over(take_over), .relay_sense(relay_sense), .remote_in(remote_in));
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  // The request is held until ready is seen at an edge; no wait state is assumed.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] mk,
    input logic e);
    int n;
    notes.push_back({e, mk, d});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      num_errors++;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so a following call never drives psel twice in one time step.
    @(posedge pclk);
  endtask
  task automatic kw(input logic [31:0] d);
    apb(1'b1, LAPC_ADDR_KEYS, d, 32'h0, 1'b0);
    repeat (3) @(posedge pclk);
  endtask
  task automatic dig();
    logic [3:0] d;
    d = 4'($urandom % 10);
    kw(32'h10 | 32'(d));
    exp_ro[(15 - 4 * nd) -: 4] = d;
    nd++;
    chk("readout", 32'(exp_ro), 32'(readout));
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // Clock, watchdog and read monitor
  // ----------------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // The whole run needs about 1200 cycles; this leaves a wide margin.
  initial
  begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    report_and_stop();
  end
  // Each completed transfer retires the oldest note; writes carry a zero mask.
  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1)
    begin
      nt = notes.pop_front();
      chk("prdata", nt[31:0] & nt[63:32], prdata & nt[63:32]);
      chk("pslverr", 32'(nt[64]), 32'(pslverr));
    end
  end
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    {presetn, psel, penable, pwrite, take_over} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    sense_mode = 2'h1;
    void'($urandom(32'h36e15ad7));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    exp_ro = 16'hffff;
    nd = 0;
    apb(1'b0, LAPC_ADDR_CTRL, 32'h0, 32'h3, 1'b0);
    apb(1'b0, LAPC_ADDR_SEL, 32'h11, 32'h3fff, 1'b0);
    dig();
    dig();
    for (k = 0; k < 6; k++)
    begin
      t = tbl[k];
      dig();
      dig();
      apb(1'b1, LAPC_ADDR_CTRL, 32'(t[9]) << 1, 32'h0, 1'b0);
      sense_mode <= t[7:6];
      kw(32'h1 << (LAPC_KEY_MON_BIT + 32'(t[8])));
      repeat (110) @(posedge pclk);
      m = t[4] ? 5'h10 : (t[9] ? 5'h1c : 5'h1f);
      chk("access", 32'(t[4:0] & m), 32'({lamps[7], line, equip, break_access_key, mon} & m));
      if (!t[4])
        chk("monlamp", 32'(t[4:0] == 5'b01001), 32'(lamps[5]));
      if (k == 0)
      begin
        apb(1'b0, LAPC_ADDR_STAT, 32'h102, 32'h3ff, 1'b0);
        apb(1'b0, LAPC_ADDR_ADDR, 32'h40000 | 32'(exp_ro), 32'h7ffff, 1'b0);
        kw(32'h1 << LAPC_KEY_BRK_BIT);
        chk("brk", 32'h0, 32'(break_access_key));
        kw(32'h1 << LAPC_KEY_METER_ON_KEY_BIT);
        kw(32'h1 << LAPC_KEY_METER_REVERSE_KEY_BIT);
        chk("meter", 32'hf, 32'({mtr, swp, lamps[9], lamps[10]}));
        kw(32'h1 << LAPC_KEY_EXT_BIT);
        chk("ext", 32'h4, 32'({ext, jack, line}));
        kw(32'h1 << LAPC_KEY_EXT_BIT);
        chk("extoff", 32'h0, 32'(ext));
        kw(32'h1 << LAPC_KEY_RELEASE_KEY_BIT);
        chk("release_key", 32'h0, 32'({mon, mtr, lamps[5]}));
      end
      kw(32'h1 << LAPC_KEY_RELEASE_CIRCUIT_KEY_BIT);
      exp_ro[7:0] = 8'hff;
      nd = 2;
      chk("rlseckt", 32'({exp_ro, 3'h0}), 32'({readout, lamps[7], mon, break_access_key}));
    end
    kw(32'h1 << LAPC_KEY_METER_ON_KEY_BIT);
    chk("mtrearly", 32'h0, 32'(mtr));
    z = 1'b0;
    for (i = 0; i < 10; i++)
    begin
      apb(1'b1, LAPC_ADDR_SEL, (32'h1 << (i % 4)) | (32'h10 << i), 32'h0, 1'b0);
      kw(32'h1 << LAPC_KEY_ZERO_BIT);
      z = ~z;
      apb(1'b0, LAPC_ADDR_LAMP, (32'h10000 << i) | (32'h1000 << (i % 4)) | (32'(z) << 11),
        32'h03fff800, 1'b0);
    end
    apb(1'b1, LAPC_ADDR_SEL, 32'h3, 32'h0, 1'b0);
    apb(1'b0, LAPC_ADDR_SEL, 32'h2002, 32'h3fff, 1'b0);
    apb(1'b1, LAPC_ADDR_CTRL, 32'h0, 32'h0, 1'b0);
    sense_mode <= 2'h1;
    dig();
    dig();
    kw(32'h1 << LAPC_KEY_MON_BIT);
    repeat (110) @(posedge pclk);
    take_over <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("remote", 32'hffff0000, {readout, lamps});
    chk("takeover", 32'h4, 32'({rci, mon, line}));
    kw(32'h1 << LAPC_KEY_MON_BIT);
    chk("manual", 32'h0, 32'(mon));
    apb(1'b0, LAPC_ADDR_CTRL, 32'h1, 32'h1, 1'b0);
    apb(1'b0, 12'h020, 32'h0, 32'hffffffff, 1'b1);
    take_over <= 1'b0;
    repeat (8) @(posedge pclk);
    report_and_stop();
  end
endmodule // lapc_top_tb
`default_nettype wire
